// >>> src/prc_phy_pkt.sv
// confirmation receive and resume transmit framer
`timescale 1ns/1ps
`default_nettype none
module prc_phy_pkt #(
    parameter int BUF_DEPTH = 2
) (
    // clock and reset
    input  wire logic                  REF_CLK_IN,
    input  wire logic                  RESETN_IN,
    // received phy packet quadlets
    input  wire logic                  RX_VALID_IN,
    input  wire logic [31:0]           RX_QUAD_IN,
    input  wire logic                  RX_LAST_IN,
    input  wire prc_pkg::prc_speed_t   RX_SPEED_IN,
    input  wire logic [4:0]            RX_ACK_IN,
    output logic                       RX_READY_OUT,
    // receive status
    output logic                       RX_ERROR_OUT,
    output logic                       RX_IGNORED_OUT,
    output logic                       CONF_VALID_OUT,
    output prc_pkg::prc_confirm_t      CONF_QUAD_OUT,
    // stored stream towards the receive buffer
    output logic                       STORE_VALID_OUT,
    output logic [31:0]                STORE_WORD_OUT,
    output logic                       STORE_FIRST_OUT,
    output logic                       STORE_LAST_OUT,
    input  wire logic                  STORE_READY_IN,
    // resume request
    input  wire logic                  RESUME_REQ_IN,
    input  wire logic [5:0]            NODE_ID_IN,
    output logic                       RESUME_BUSY_OUT,
    // transmit stream towards the phy
    output logic                       TX_VALID_OUT,
    output logic [31:0]                TX_QUAD_OUT,
    output logic                       TX_LAST_OUT,
    input  wire logic                  TX_READY_IN
);
    localparam int WW = $bits(prc_pkg::prc_word_t);

    typedef enum logic [2:0] {
        PRC_RX_IDLE  = 3'h0,
        PRC_RX_HALF  = 3'h1,
        PRC_RX_TOKEN = 3'h3,
        PRC_RX_Q0    = 3'h2,
        PRC_RX_Q1    = 3'h6,
        PRC_RX_DROP  = 3'h7
    } prc_rx_state_t;

    typedef enum logic [1:0] {
        PRC_TX_IDLE = 2'h0,
        PRC_TX_Q0   = 2'h1,
        PRC_TX_Q1   = 2'h3
    } prc_tx_state_t;

    // receive state
    prc_rx_state_t         rs_q;
    prc_rx_state_t         rs_d;
    logic [31:0]           q0_q;
    logic [31:0]           q0_d;
    logic [31:0]           q1_q;
    logic [31:0]           q1_d;
    prc_pkg::prc_speed_t   spd_q;
    prc_pkg::prc_speed_t   spd_d;
    logic [4:0]            ack_q;
    logic [4:0]            ack_d;
    logic                  err_q;
    logic                  err_d;
    logic                  ign_q;
    logic                  ign_d;
    logic                  cvalid_q;
    logic                  cvalid_d;
    prc_pkg::prc_confirm_t conf_q;
    prc_pkg::prc_confirm_t conf_d;

    // transmit state
    prc_tx_state_t         ts_q;
    prc_tx_state_t         ts_d;
    logic [31:0]           tq_q;
    logic [31:0]           tq_d;

    // datapath wires
    prc_pkg::prc_confirm_t rx_head;
    prc_pkg::prc_token_t   token;
    prc_pkg::prc_resume_t  resume;
    prc_pkg::prc_word_t    rx_word;
    prc_pkg::prc_word_t    tx_word;
    prc_pkg::prc_word_t    store_word;
    prc_pkg::prc_word_t    txo_word;
    logic                  rx_match;
    logic [31:0]           tx_inverse;
    logic                  rx_push;
    logic                  rx_buf_ready;
    logic                  tx_push;
    logic                  tx_buf_ready;
    logic                  rx_take;
    logic                  is_confirm;

    assign rx_head = prc_pkg::prc_confirm_t'(q0_q);

    // only a phy ident with the confirmation type is taken
    assign is_confirm = (rx_head.ident == prc_pkg::PHY_PKT_IDENT) &&
                        (rx_head.ext_type == prc_pkg::TYPE_CONFIRM);

    // second quadlet must be the bitwise inverse of the first
    prc_inv_check u_rx_check (
        .first_in    (q0_q),
        .second_in   (RX_QUAD_IN),
        .inverse_out (),
        .match_out   (rx_match)
    );

    // token built from what arrived with the last quadlet
    always_comb begin
        token                        = '0;
        token.token_quadlet_count    = prc_pkg::CONF_QUADLETS;
        token.self_id                = prc_pkg::TOKEN_SELF_ID;
        token.phy_packet             = prc_pkg::TOKEN_PHY_PKT;
        token.acknowledge_code_field = ack_q;
        token.pad_bytes              = prc_pkg::CONF_PAD_BYTES;
        token.speed                  = spd_q;
    end

    // receive framing: hold the source off until the token and both quadlets are pushed into the store buffer
    assign RX_READY_OUT = (rs_q == PRC_RX_IDLE) ||
                          (rs_q == PRC_RX_HALF) ||
                          (rs_q == PRC_RX_DROP);
    assign rx_take      = RX_VALID_IN && RX_READY_OUT;

    always_comb begin
        rs_d     = rs_q;
        q0_d     = q0_q;
        q1_d     = q1_q;
        spd_d    = spd_q;
        ack_d    = ack_q;
        err_d    = 1'b0;
        ign_d    = 1'b0;
        cvalid_d = 1'b0;
        conf_d   = conf_q;
        rx_push  = 1'b0;
        rx_word  = '0;
        case (rs_q)
            PRC_RX_IDLE: begin
                if (rx_take) begin
                    q0_d = RX_QUAD_IN;
                    if (RX_LAST_IN) begin
                        // a lone quadlet cannot be a checked phy packet
                        err_d = 1'b1;
                    end else begin
                        rs_d = PRC_RX_HALF;
                    end
                end
            end
            PRC_RX_HALF: begin
                if (rx_take) begin
                    if (!RX_LAST_IN) begin
                        err_d = 1'b1;
                        rs_d  = PRC_RX_DROP;
                    end else if (!rx_match) begin
                        err_d = 1'b1;
                        rs_d  = PRC_RX_IDLE;
                    end else if (!is_confirm) begin
                        // other phy packets belong to other framers
                        ign_d = 1'b1;
                        rs_d  = PRC_RX_IDLE;
                    end else begin
                        q1_d     = RX_QUAD_IN;
                        spd_d    = RX_SPEED_IN;
                        ack_d    = RX_ACK_IN;
                        conf_d   = rx_head;
                        cvalid_d = 1'b1;
                        rs_d     = PRC_RX_TOKEN;
                    end
                end
            end
            PRC_RX_TOKEN: begin
                rx_push       = 1'b1;
                rx_word.first = 1'b1;
                rx_word.data  = token;
                if (rx_buf_ready) begin
                    rs_d = PRC_RX_Q0;
                end
            end
            PRC_RX_Q0: begin
                rx_push      = 1'b1;
                rx_word.data = q0_q;
                if (rx_buf_ready) begin
                    rs_d = PRC_RX_Q1;
                end
            end
            PRC_RX_Q1: begin
                rx_push      = 1'b1;
                rx_word.last = 1'b1;
                rx_word.data = q1_q;
                if (rx_buf_ready) begin
                    rs_d = PRC_RX_IDLE;
                end
            end
            PRC_RX_DROP: begin
                // overlong packet: swallow the rest silently
                if (rx_take && RX_LAST_IN) begin
                    rs_d = PRC_RX_IDLE;
                end
            end
            default: begin
                rs_d = PRC_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rs_q     <= PRC_RX_IDLE;
            q0_q     <= '0;
            q1_q     <= '0;
            spd_q    <= prc_pkg::PRC_SPD_100;
            ack_q    <= '0;
            err_q    <= 1'b0;
            ign_q    <= 1'b0;
            cvalid_q <= 1'b0;
            conf_q   <= '0;
        end else begin
            rs_q     <= rs_d;
            q0_q     <= q0_d;
            q1_q     <= q1_d;
            spd_q    <= spd_d;
            ack_q    <= ack_d;
            err_q    <= err_d;
            ign_q    <= ign_d;
            cvalid_q <= cvalid_d;
            conf_q   <= conf_d;
        end
    end

    assign RX_ERROR_OUT   = err_q;
    assign RX_IGNORED_OUT = ign_q;
    assign CONF_VALID_OUT = cvalid_q;
    assign CONF_QUAD_OUT  = conf_q;

    prc_skid_buf #(
        .WIDTH (WW),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .clk_in        (REF_CLK_IN),
        .resetn_in     (RESETN_IN),
        .in_valid_in   (rx_push),
        .in_data_in    (rx_word),
        .in_ready_out  (rx_buf_ready),
        .out_valid_out (STORE_VALID_OUT),
        .out_data_out  (store_word),
        .out_ready_in  (STORE_READY_IN)
    );

    assign STORE_WORD_OUT  = store_word.data;
    assign STORE_FIRST_OUT = store_word.first;
    assign STORE_LAST_OUT  = store_word.last;

    // resume quadlet: everything outside the named fields is zero
    always_comb begin
        resume                     = '0;
        resume.ident               = prc_pkg::PHY_PKT_IDENT;
        resume.physical_node_ident = NODE_ID_IN;
        resume.ext_type            = prc_pkg::TYPE_RESUME;
        resume.fixed               = prc_pkg::RESUME_FIXED;
    end

    // hardware makes the trailer, software only asks
    prc_inv_check u_tx_inv (
        .first_in    (tq_q),
        .second_in   (tq_q),
        .inverse_out (tx_inverse),
        .match_out   ()
    );

    // requests arriving while a resume is in flight are dropped
    assign RESUME_BUSY_OUT = (ts_q != PRC_TX_IDLE);

    always_comb begin
        ts_d    = ts_q;
        tq_d    = tq_q;
        tx_push = 1'b0;
        tx_word = '0;
        case (ts_q)
            PRC_TX_IDLE: begin
                if (RESUME_REQ_IN) begin
                    tq_d = resume;
                    ts_d = PRC_TX_Q0;
                end
            end
            PRC_TX_Q0: begin
                tx_push       = 1'b1;
                tx_word.first = 1'b1;
                tx_word.data  = tq_q;
                if (tx_buf_ready) begin
                    ts_d = PRC_TX_Q1;
                end
            end
            PRC_TX_Q1: begin
                tx_push      = 1'b1;
                tx_word.last = 1'b1;
                tx_word.data = tx_inverse;
                if (tx_buf_ready) begin
                    ts_d = PRC_TX_IDLE;
                end
            end
            default: begin
                ts_d = PRC_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ts_q <= PRC_TX_IDLE;
            tq_q <= '0;
        end else begin
            ts_q <= ts_d;
            tq_q <= tq_d;
        end
    end

    prc_skid_buf #(
        .WIDTH (WW),
        .DEPTH (BUF_DEPTH)
    ) u_tx_buf (
        .clk_in        (REF_CLK_IN),
        .resetn_in     (RESETN_IN),
        .in_valid_in   (tx_push),
        .in_data_in    (tx_word),
        .in_ready_out  (tx_buf_ready),
        .out_valid_out (TX_VALID_OUT),
        .out_data_out  (txo_word),
        .out_ready_in  (TX_READY_IN)
    );

    assign TX_QUAD_OUT = txo_word.data;
    assign TX_LAST_OUT = txo_word.last;
endmodule
`default_nettype wire

// >>> src/prc_pkg.sv
// shared types and constants for the phy packet framer
package prc_pkg;

    // first quadlet layout
    localparam logic [1:0] PHY_PKT_IDENT   = 2'h0;
    localparam logic [3:0] TYPE_COMMAND    = 4'h8;
    localparam logic [3:0] TYPE_CONFIRM    = 4'ha;
    localparam logic [3:0] TYPE_RESUME     = 4'hf;
    localparam logic [3:0] PORT_STATUS_REG = 4'h8;
    localparam logic [2:0] RESUME_FIXED    = 3'h7;

    // control token values for a stored confirmation
    localparam logic [13:0] CONF_QUADLETS  = 14'h0002;
    localparam logic [1:0]  CONF_PAD_BYTES = 2'h0;
    localparam logic        TOKEN_SELF_ID  = 1'h0;
    localparam logic        TOKEN_PHY_PKT  = 1'h1;

    // bit positions of the first quadlet
    localparam int IDENT_POS = 30;
    localparam int NODE_POS  = 24;
    localparam int TYPE_POS  = 18;
    localparam int PORT_POS  = 11;

    typedef enum logic [1:0] {
        PRC_SPD_100 = 2'h0,
        PRC_SPD_200 = 2'h1,
        PRC_SPD_400 = 2'h2,
        PRC_SPD_UND = 2'h3
    } prc_speed_t;

    typedef enum logic [2:0] {
        PRC_CMD_NOP        = 3'h0,
        PRC_CMD_DISABLE    = 3'h1,
        PRC_CMD_SUSPEND    = 3'h2,
        PRC_CMD_RSV3       = 3'h3,
        PRC_CMD_CLEAR_FLT  = 3'h4,
        PRC_CMD_ENABLE     = 3'h5,
        PRC_CMD_RESUME     = 3'h6,
        PRC_CMD_RSV7       = 3'h7
    } prc_cmd_t;

    typedef struct packed {
        logic [1:0]  reserved_field_hi;
        logic [13:0] token_quadlet_count;
        logic        self_id;
        logic        phy_packet;
        logic        reserved_field_mid;
        logic [4:0]  acknowledge_code_field;
        logic [1:0]  pad_bytes;
        prc_speed_t  speed;
        logic [3:0]  reserved_field_lo;
    } prc_token_t;

    typedef struct packed {
        logic [1:0] ident;
        logic [5:0] physical_node_ident;
        logic [1:0] zero_a;
        logic [3:0] ext_type;
        logic [2:0] zero_b;
        logic [3:0] port;
        logic [2:0] zero_c;
        logic       fault;
        logic       connected;
        logic       bias;
        logic       disabled;
        logic       accepted;
        prc_cmd_t   remote_command_code;
    } prc_confirm_t;

    typedef struct packed {
        logic [1:0] ident;
        logic [5:0] physical_node_ident;
        logic [1:0] zero_a;
        logic [3:0] ext_type;
        logic [9:0] zero_b;
        logic [2:0] fixed;
        logic [4:0] zero_c;
    } prc_resume_t;

    typedef struct packed {
        logic        first;
        logic        last;
        logic [31:0] data;
    } prc_word_t;

endpackage

// >>> src/prc_inv_check.sv
// inverse quadlet generator and comparator
`timescale 1ns/1ps
`default_nettype none
module prc_inv_check (
    // quadlets
    input  wire logic [31:0] first_in,
    input  wire logic [31:0] second_in,
    // results
    output logic      [31:0] inverse_out,
    output logic             match_out
);
    assign inverse_out = ~first_in;
    assign match_out   = (second_in == ~first_in);
endmodule
`default_nettype wire

// >>> src/prc_skid_buf.sv
// small valid/ready buffer holding DEPTH words
`timescale 1ns/1ps
`default_nettype none
module prc_skid_buf #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // drain side
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    wr_d;
    logic [AW-1:0]    rd_q;
    logic [AW-1:0]    rd_d;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    assign in_ready_out  = (cnt_q != FULL);
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data_in;
            wr_d        = (wr_q == LAST) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// >>> sim/prc_phy_pkt_assertions.sv
// port checker for the phy packet framer
`timescale 1ns/1ps
`default_nettype none
module prc_phy_pkt_assertions #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic                  REF_CLK_IN,
    input wire logic                  RESETN_IN,
    input wire logic                  RX_READY_OUT,
    input wire logic                  RX_ERROR_OUT,
    input wire logic                  RX_IGNORED_OUT,
    input wire logic                  CONF_VALID_OUT,
    input wire prc_pkg::prc_confirm_t CONF_QUAD_OUT,
    input wire logic                  STORE_VALID_OUT,
    input wire logic [31:0]           STORE_WORD_OUT,
    input wire logic                  STORE_FIRST_OUT,
    input wire logic                  STORE_READY_IN,
    input wire logic                  RESUME_REQ_IN,
    input wire logic                  RESUME_BUSY_OUT,
    input wire logic                  TX_VALID_OUT,
    input wire logic [31:0]           TX_QUAD_OUT,
    input wire logic                  TX_LAST_OUT
);
    logic [31:0] first_q;
    logic [31:0] first_d;

    // last first quadlet shown, so the inverse can be judged under stall
    always_comb first_d = (TX_VALID_OUT && !TX_LAST_OUT) ? TX_QUAD_OUT
                                                         : first_q;
    always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
        if (!RESETN_IN)
            first_q <= 32'h0;
        else
            first_q <= first_d;

    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    chk_busy_on_req:
        assert property (RESUME_REQ_IN && !RESUME_BUSY_OUT |=> RESUME_BUSY_OUT)
        else $error("resume request not taken");
    chk_tx_type:
        assert property (TX_VALID_OUT && !TX_LAST_OUT |->
            TX_QUAD_OUT[21:18] == 4'hf)
        else $error("resume type wrong");
    chk_tx_zeros:
        assert property (TX_VALID_OUT && !TX_LAST_OUT |->
            TX_QUAD_OUT[31:30] == 2'h0 && TX_QUAD_OUT[23:22] == 2'h0 &&
            TX_QUAD_OUT[17:0] == 18'h000e0)
        else $error("resume constant bits wrong");
    chk_tx_inverse:
        assert property (TX_VALID_OUT && TX_LAST_OUT |->
            TX_QUAD_OUT == ~first_q)
        else $error("resume second quadlet not inverse");
    chk_conf_type:
        assert property (CONF_VALID_OUT |-> CONF_QUAD_OUT.ident == 2'h0 &&
            CONF_QUAD_OUT.ext_type == 4'ha)
        else $error("confirmation with wrong type");
    chk_conf_hold:
        assert property (!CONF_VALID_OUT |-> $stable(CONF_QUAD_OUT))
        else $error("confirmation changed without pulse");
    chk_ready_drop:
        assert property (CONF_VALID_OUT |-> !RX_READY_OUT [*3])
        else $error("ready back before words stored");
    chk_token_bits:
        assert property (STORE_VALID_OUT && STORE_FIRST_OUT |->
            STORE_WORD_OUT[31:13] == {2'h0, 14'h0002, 3'h2} &&
            STORE_WORD_OUT[7:6] == 2'h0 && STORE_WORD_OUT[3:0] == 4'h0)
        else $error("token fields wrong");
    chk_one_verdict:
        assert property ($onehot0({CONF_VALID_OUT, RX_ERROR_OUT,
            RX_IGNORED_OUT}))
        else $error("two packet verdicts at once");
    chk_store_hold:
        assert property (STORE_VALID_OUT && !STORE_READY_IN |=>
            STORE_VALID_OUT && $stable(STORE_WORD_OUT))
        else $error("stored word lost under stall");
endmodule
bind prc_phy_pkt prc_phy_pkt_assertions #(.BUF_DEPTH(BUF_DEPTH)) u_chk (.*);
`default_nettype wire

// >>> sim/prc_far_phy.sv
// far phy model: sends replies, sinks transmit quadlets
`timescale 1ns/1ps
`default_nettype none
module prc_far_phy (
    // link side
    input  wire logic          clk_in,
    input  wire logic          rx_ready_in,
    input  wire logic          tx_stall_in,
    output logic               rx_valid_out,
    output logic [31:0]        rx_quad_out,
    output logic               rx_last_out,
    output prc_pkg::prc_speed_t rx_speed_out,
    output logic [4:0]         rx_ack_out,
    output logic               tx_ready_out
);
    assign tx_ready_out = !tx_stall_in;
    initial begin
        rx_valid_out = 1'b0;
        rx_quad_out = 32'h0;
        rx_last_out = 1'b0;
        rx_speed_out = prc_pkg::PRC_SPD_100;
        rx_ack_out = 5'h0;
    end
    // status flags come from the port status register of the far phy
    function automatic logic [31:0] reply(input logic [5:0] dest,
        input logic [3:0] port, input logic [3:0] flags, input logic ok,
        input logic [2:0] cmd);
        return {2'h0, dest, 2'h0, prc_pkg::TYPE_CONFIRM, 3'h0, port, 3'h0,
            flags, ok, cmd};
    endfunction
    // entered just after a falling edge; holds until taken
    task automatic put(input logic [31:0] q, input logic last);
        int n;
        n = 0;
        rx_valid_out = 1'b1;
        rx_quad_out = q;
        rx_last_out = last;
        #1;
        while (!rx_ready_in && n < 60) begin
            @(negedge clk_in);
            #1;
            n++;
        end
        @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task automatic send(input logic [31:0] q0, input logic [31:0] q1,
        input logic lone, input logic [1:0] spd, input logic [4:0] ack);
        rx_speed_out = prc_pkg::prc_speed_t'(spd);
        rx_ack_out = ack;
        if (!lone)
            put(q0, 1'b0);
        put(lone ? q0 : q1, 1'b1);
        // released data never repeats the last value
        rx_valid_out = 1'b0;
        rx_quad_out = ~rx_quad_out;
    endtask
endmodule
`default_nettype wire

// >>> sim/prc_phy_pkt_test.sv
// self-checking bench for the phy packet framer
`timescale 1ns/1ps
`default_nettype none
module prc_phy_pkt_test;
    logic clk = 1'b0;
    logic rstn, rx_valid, rx_last, rx_ready, rx_err, rx_ign, conf_valid;
    logic st_valid, st_first, st_last, store_rdy, req, busy;
    logic tx_valid, tx_last, tx_rdy, tx_stall;
    logic [31:0] rx_quad, st_word, tx_quad, q, qb;
    logic [33:0] tok;
    logic [4:0] rx_ack;
    logic [5:0] node;
    logic [2:0] cmds [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    prc_pkg::prc_speed_t rx_speed;
    prc_pkg::prc_confirm_t conf_quad;
    int error_cnt, total_checks, n_conf, n_err, n_ign, k;
    logic [33:0] st_q [$];
    logic [32:0] tx_q [$];

    always #10 clk = ~clk;

    prc_phy_pkt #(.BUF_DEPTH(2)) u_dut (
        .REF_CLK_IN(clk), .RESETN_IN(rstn),
        .RX_VALID_IN(rx_valid), .RX_QUAD_IN(rx_quad), .RX_LAST_IN(rx_last),
        .RX_SPEED_IN(rx_speed), .RX_ACK_IN(rx_ack),
        .RX_READY_OUT(rx_ready), .RX_ERROR_OUT(rx_err),
        .RX_IGNORED_OUT(rx_ign), .CONF_VALID_OUT(conf_valid),
        .CONF_QUAD_OUT(conf_quad), .STORE_VALID_OUT(st_valid),
        .STORE_WORD_OUT(st_word), .STORE_FIRST_OUT(st_first),
        .STORE_LAST_OUT(st_last), .STORE_READY_IN(store_rdy),
        .RESUME_REQ_IN(req), .NODE_ID_IN(node), .RESUME_BUSY_OUT(busy),
        .TX_VALID_OUT(tx_valid), .TX_QUAD_OUT(tx_quad),
        .TX_LAST_OUT(tx_last), .TX_READY_IN(tx_rdy));

    prc_far_phy u_far (
        .clk_in(clk), .rx_ready_in(rx_ready), .tx_stall_in(tx_stall),
        .rx_valid_out(rx_valid), .rx_quad_out(rx_quad),
        .rx_last_out(rx_last), .rx_speed_out(rx_speed),
        .rx_ack_out(rx_ack), .tx_ready_out(tx_rdy));

    always @(posedge clk) begin
        if (st_valid && store_rdy)
            st_q.push_back({st_first, st_last, st_word});
        if (tx_valid && tx_rdy)
            tx_q.push_back({tx_last, tx_quad});
        n_conf += 32'(conf_valid);
        n_err += 32'(rx_err);
        n_ign += 32'(rx_ign);
    end

    task automatic cmp(input string what, input logic [33:0] got,
        input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // a bad packet must leave the store and the last confirmation alone
    task automatic fault(input logic [31:0] q0, input logic [31:0] q1,
        input logic lone, input int e_err, input int e_ign);
        int b_err;
        int b_ign;
        b_err = n_err;
        b_ign = n_ign;
        u_far.send(q0, q1, lone, 2'h0, 5'h1);
        repeat (4) @(negedge clk);
        cmp("error pulses", 34'(n_err - b_err), 34'(e_err));
        cmp("ignore pulses", 34'(n_ign - b_ign), 34'(e_ign));
        cmp("stored words", 34'(st_q.size()), 34'h0);
        cmp("confirm kept", {2'h0, conf_quad}, {2'h0, q});
    endtask
    task automatic resume(input logic [5:0] id, input int hold);
        int n;
        n = 0;
        req = 1'b1;
        node = id;
        repeat (hold) @(negedge clk);
        req = 1'b0;
        @(negedge clk);
        while (busy && n < 50) begin
            @(negedge clk);
            n++;
        end
    endtask

    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        rstn = 1'b0;
        store_rdy = 1'b1;
        req = 1'b0;
        node = 6'h0;
        tx_stall = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        // even passes stall the store so the two-entry buffer fills
        for (int i = 0; i < 6; i++) begin
            q = u_far.reply(6'h21 + 6'(i), 4'(i), 4'(i) ^ 4'h9, i[0], cmds[i]);
            store_rdy = i[0];
            u_far.send(q, ~q, 1'b0, 2'(i), 5'h11 + 5'(i));
            repeat (3) @(negedge clk);
            store_rdy = 1'b1;
            for (k = 0; k < 60 && st_q.size() < 3; k++)
                @(negedge clk);
            tok = {4'h8, 14'h0002, 3'h2, 5'h11 + 5'(i), 2'h0, 2'(i), 4'h0};
            cmp("confirm", {2'h0, conf_quad}, {2'h0, q});
            cmp("confirm pulses", 34'(n_conf), 34'(i + 1));
            cmp("token", st_q[0], tok);
            cmp("quad one", st_q[1], {2'h0, q});
            cmp("quad two", st_q[2], {2'h1, ~q});
            st_q.delete();
        end
        qb = q;
        fault(qb, qb ^ 32'h1, 1'b0, 1, 0);
        qb = {q[31:22], prc_pkg::TYPE_COMMAND, q[17:0]};
        fault(qb, ~qb, 1'b0, 0, 1);
        qb = {2'h1, q[29:0]};
        fault(qb, ~qb, 1'b0, 0, 1);
        fault(q, q, 1'b1, 1, 0);
        // overlong packet: error after the second quadlet, rest swallowed
        u_far.put(q, 1'b0);
        fault(~q, q, 1'b0, 1, 0);
        // request held into busy must give one packet only
        tx_stall = 1'b1;
        resume(6'h2a, 2);
        repeat (5) @(negedge clk);
        tx_stall = 1'b0;
        resume(6'h15, 1);
        for (k = 0; k < 60 && tx_q.size() < 4; k++)
            @(negedge clk);
        repeat (4) @(negedge clk);
        cmp("resume words", 34'(tx_q.size()), 34'h4);
        for (int j = 0; j < 2; j++) begin
            q = {2'h0, j ? 6'h15 : 6'h2a, 2'h0, 4'hf, 10'h0, 3'h7, 5'h0};
            cmp("resume first", 34'(tx_q[2 * j]), {2'h0, q});
            cmp("resume second", 34'(tx_q[2 * j + 1]), {2'h1, ~q});
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
